/* rtl/pin_cfg_pkg.sv */
// shared constants and types for the pin function configuration block
// Functional notes
// (R1) Pull control bit 7 enables the pin pull-up resistor.
// (R2) Bit 6 enables pull-down only when pull-up is not also enabled.
// (R3) Handshake-out pins: 3-bit code selects GPIO in/OD/PP or handshake OD/PP.
// (R4) Host pairs handshake-out with handshake-in and leaves the partner pin as GPIO.
// (R5) Carrier pin: 2-bit code selects GPIO input, open-drain or push-pull.
// (R6) Ring pin: 2-bit code selects GPIO in, OD, PP or ring input.
// (R7) Ring byte bit 5 enables ring pin as remote-wakeup source.
// (R8) Host enables remote wakeup globally before pin wakeup enables matter.
// (R9) Serial byte: bits 7:6 pull receive pin, bit 5 enables receive wakeup.
// (R10) Serial byte bits 1:0 select transmit open-drain or push-pull; receive fixed.
// (R11) Indicator codes 000/100: first high, second low in suspend or bus reset.
// (R12) Codes 001 suspend, 010 suspend or unconfigured, 011 bus reset, active high.
// (R13) Codes 101, 110, 111 mirror 001, 010, 011 but active low.
// (R14) Indicator bits 1:0 select open-drain or push-pull; others reserved.
// (R15) Suspend masks map GPIO0-3, 4-5, 6-9 to bits 3:0, 7:6, 13:10.
// (R16) Override off: GPIOs hold their pre-suspend output state in suspend.
// (R17) Override on: GPIOs take suspend mask level and drive type.
// (R18) Level mask bit 0 drives low, 1 drives high.
// (R19) Drive mask bit 0 gives open-drain, 1 gives push-pull.
// (R20) Override on: clock-output GPIO0 held low in suspend.
// (R21) Override on: RS-485 direction pin held deasserted in suspend.
// (R22) Defaults: transmit 0x02, GPIO0/6/7 0x00, GPIO1-5 0x03, GPIO8/9 0x02.
// (R23) Host enables hardware flow control before relying on default handshake pins.
// (R24) Reserved codes leave the pin as high-impedance input; reserved bits read zero.
package pin_cfg_pkg;
    localparam int NUM_GPIO = 10;
    localparam int IDX_W = 5;
    localparam int LAST_IDX = 19;
    // byte positions inside the configuration report
    localparam logic [4:0] IDX_REPORT_ID = 5'h00;
    localparam logic [4:0] IDX_CLK = 5'h01;
    localparam logic [4:0] IDX_RTS = 5'h02;
    localparam logic [4:0] IDX_CTS = 5'h03;
    localparam logic [4:0] IDX_RS485 = 5'h04;
    localparam logic [4:0] IDX_TX_TG = 5'h05;
    localparam logic [4:0] IDX_RX_TG = 5'h06;
    localparam logic [4:0] IDX_CD = 5'h07;
    localparam logic [4:0] IDX_RI = 5'h08;
    localparam logic [4:0] IDX_DTR = 5'h09;
    localparam logic [4:0] IDX_DSR = 5'h0A;
    localparam logic [4:0] IDX_SER = 5'h0B;
    localparam logic [4:0] IDX_IND_A = 5'h0C;
    localparam logic [4:0] IDX_IND_B = 5'h0D;
    localparam logic [4:0] IDX_LVL_MSB = 5'h0E;
    localparam logic [4:0] IDX_LVL_LSB = 5'h0F;
    localparam logic [4:0] IDX_DRV_MSB = 5'h10;
    localparam logic [4:0] IDX_DRV_LSB = 5'h11;
    localparam logic [4:0] IDX_RS485_POL = 5'h12;
    localparam logic [4:0] IDX_CLKDIV = 5'h13;
    localparam logic [7:0] REPORT_ID = 8'h66;
    // field positions
    localparam int PULL_UP_BIT = 7;
    localparam int PULL_DN_BIT = 6;
    localparam int WAKE_BIT = 5;
    localparam int OVERRIDE_BIT = 15;
    // writable-bit masks, reserved bits stay zero
    localparam logic [7:0] MASK_GEN = 8'hC3;
    localparam logic [7:0] MASK_HSO = 8'hC7;
    localparam logic [7:0] MASK_WAKE = 8'hE3;
    localparam logic [7:0] MASK_IND = 8'h1F;
    localparam logic [7:0] MASK_LVL_MSB = 8'h3C;
    localparam logic [7:0] MASK_DRV_MSB = 8'hBC;
    localparam logic [7:0] MASK_MASK_LSB = 8'hCF;
    localparam logic [7:0] MASK_POL = 8'h01;
    localparam logic [7:0] MASK_ALL = 8'hFF;
    // reset values
    localparam logic [7:0] RST_GPIO_IN = 8'h00;
    localparam logic [7:0] RST_FUNC = 8'h03;
    localparam logic [7:0] RST_PP = 8'h02;
    localparam logic [7:0] RST_IND_A = 8'h0A;
    localparam logic [7:0] RST_IND_B = 8'h1A;
    localparam logic [7:0] RST_POL = 8'h01;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // function codes
    localparam logic [1:0] C2_IN = 2'b00;
    localparam logic [1:0] C2_OD = 2'b01;
    localparam logic [1:0] C2_PP = 2'b10;
    localparam logic [1:0] C2_FN = 2'b11;
    localparam logic [2:0] C3_IN = 3'b000;
    localparam logic [2:0] C3_OD = 3'b001;
    localparam logic [2:0] C3_PP = 3'b010;
    localparam logic [2:0] C3_FN_OD = 3'b011;
    localparam logic [2:0] C3_FN_PP = 3'b100;
    typedef enum logic [1:0] {DRV_IN, DRV_OD, DRV_PP} drive_t;
endpackage

/* rtl/pin_drive_cell.sv */
// one pad driver with suspend hold and suspend override
module pin_drive_cell (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire pin_cfg_pkg::drive_t i_mode,
    input wire logic i_level,
    input wire logic i_suspend,
    input wire logic i_override,
    input wire logic i_sus_level,
    input wire logic i_sus_drive,
    input wire logic i_force,
    input wire logic i_force_level,
    output logic o_pad_out,
    output logic o_pad_oe
);
    import pin_cfg_pkg::*;
    logic out_d;
    logic oe_d;
    drive_t eff_mode;
    logic eff_level;

    always_comb begin
        eff_mode = i_mode;
        eff_level = i_level;
        if (i_suspend && i_override) begin
            // (R17) suspend override mask
            eff_level = i_sus_level;
            // (R19) drive mask type
            eff_mode = i_sus_drive ? DRV_PP : DRV_OD;
            if (i_force) begin
                eff_mode = DRV_PP;
                eff_level = i_force_level;
            end
        end
        unique case (eff_mode)
            DRV_OD: begin
                out_d = 1'b0;
                oe_d = !eff_level;
            end
            DRV_PP: begin
                out_d = eff_level;
                oe_d = 1'b1;
            end
            default: begin
                out_d = 1'b0;
                oe_d = 1'b0;
            end
        endcase
        // (R16) hold pre-suspend state
        if (i_suspend && !i_override) begin
            out_d = o_pad_out;
            oe_d = o_pad_oe;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_pad_out <= 1'b0;
            o_pad_oe <= 1'b0;
        end else begin
            o_pad_out <= out_d;
            o_pad_oe <= oe_d;
        end
    end

    // (R18) level mask drives pad
    sus_level_a: assert property (@(posedge i_core_clk) disable iff (!i_rst_n) // R18
        i_suspend && i_override && !i_force && i_sus_drive |=> o_pad_out == $past(i_sus_level)
    ) else $error("suspend level not applied");
endmodule

/* rtl/gpio_pin_function_config.sv */
// pin function, pull, indicator and suspend configuration for the bridge pins
module gpio_pin_function_config (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [pin_cfg_pkg::IDX_W-1:0] i_cfg_idx,
    input wire logic [7:0] i_cfg_wdata,
    input wire logic i_cfg_end,
    input wire logic i_usb_suspend,
    input wire logic i_usb_bus_reset,
    input wire logic i_usb_configured,
    input wire logic i_usb_rwake_en,
    input wire logic [pin_cfg_pkg::NUM_GPIO-1:0] i_gpio_level,
    input wire logic [pin_cfg_pkg::NUM_GPIO-1:0] i_pad_in,
    input wire logic i_rx_pad_in,
    input wire logic i_txd,
    input wire logic i_rts_n,
    input wire logic i_dtr_n,
    input wire logic i_clk_gen,
    input wire logic i_rs485_dir,
    input wire logic i_tx_toggle_out,
    input wire logic i_rx_toggle_out,
    output logic [7:0] o_cfg_rdata,
    output logic o_cfg_locked,
    output logic [pin_cfg_pkg::NUM_GPIO-1:0] o_pad_out,
    output logic [pin_cfg_pkg::NUM_GPIO-1:0] o_pad_oe,
    output logic [pin_cfg_pkg::NUM_GPIO-1:0] o_pull_up,
    output logic [pin_cfg_pkg::NUM_GPIO-1:0] o_pull_dn,
    output logic [pin_cfg_pkg::NUM_GPIO-1:0] o_pin_in,
    output logic o_cts_in_n,
    output logic o_dsr_in_n,
    output logic o_ri_in_n,
    output logic o_tx_out,
    output logic o_tx_oe,
    output logic o_rx_pull_up,
    output logic o_rx_pull_dn,
    output logic o_bus_indicator_a,
    output logic o_bus_indicator_a_oe,
    output logic o_bus_indicator_b,
    output logic o_bus_indicator_b_oe,
    output logic o_wake_req
);
    import pin_cfg_pkg::*;

    logic [7:0] cfg_q [1:LAST_IDX];
    logic [7:0] cfg_d [1:LAST_IDX];
    logic lock_q;
    logic lock_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    drive_t gpio_mode [NUM_GPIO];
    logic [NUM_GPIO-1:0] gpio_lvl;
    logic [NUM_GPIO-1:0] force_en;
    logic [NUM_GPIO-1:0] force_lvl;
    logic [15:0] lvl_mask;
    logic [15:0] drv_mask;
    logic override;
    logic [NUM_GPIO-1:0] pu_d, pd_d, pu_q, pd_q;
    logic [NUM_GPIO-1:0] pin_in_q;
    logic rx_in_q;
    logic tx_out_d, tx_oe_d, tx_out_q, tx_oe_q;
    logic ind_a_d, ind_a_oe_d, ind_b_d, ind_b_oe_d;
    logic ind_a_q, ind_a_oe_q, ind_b_q, ind_b_oe_q;
    logic cts_d, dsr_d, ri_d, cts_q, dsr_q, ri_q;
    logic wake_d, wake_q, rx_pu_d, rx_pd_d, rx_pu_q, rx_pd_q;

    function automatic logic [7:0] wmask(input int idx);
        unique case (idx)
            IDX_RTS, IDX_DTR: wmask = MASK_HSO;
            IDX_RI, IDX_SER: wmask = MASK_WAKE;
            IDX_IND_A, IDX_IND_B: wmask = MASK_IND;
            IDX_LVL_MSB: wmask = MASK_LVL_MSB;
            IDX_DRV_MSB: wmask = MASK_DRV_MSB;
            IDX_LVL_LSB, IDX_DRV_LSB: wmask = MASK_MASK_LSB;
            IDX_RS485_POL: wmask = MASK_POL;
            IDX_CLKDIV: wmask = MASK_ALL;
            default: wmask = MASK_GEN;
        endcase
    endfunction

    function automatic logic [7:0] rst_val(input int idx);
        unique case (idx)
            IDX_CLK, IDX_CD, IDX_RI: rst_val = RST_GPIO_IN;
            IDX_RTS, IDX_CTS, IDX_RS485, IDX_TX_TG, IDX_RX_TG: rst_val = RST_FUNC;
            IDX_DTR, IDX_DSR, IDX_SER: rst_val = RST_PP;
            IDX_IND_A: rst_val = RST_IND_A;
            IDX_IND_B: rst_val = RST_IND_B;
            IDX_RS485_POL: rst_val = RST_POL;
            default: rst_val = RST_ZERO;
        endcase
    endfunction

    // two-bit field shared by generic, carrier and ring pins
    function automatic drive_t dec2(input logic [1:0] code);
        unique case (code)
            C2_OD: dec2 = DRV_OD;
            C2_PP: dec2 = DRV_PP;
            default: dec2 = DRV_IN;
        endcase
    endfunction

    // indicator level from its code and the bus conditions
    function automatic logic ind_level(input logic [2:0] code, input logic first);
        logic act;
        logic cond;
        act = 1'b0;
        cond = 1'b0;
        unique case (code[1:0])
            2'b01: cond = i_usb_suspend;
            2'b10: cond = i_usb_suspend || !i_usb_configured;
            2'b11: cond = i_usb_bus_reset;
            default: cond = i_usb_suspend || i_usb_bus_reset;
        endcase
        if (code[1:0] == 2'b00) begin
            // (R11) first high, second low
            act = first;
        end else begin
            // (R13) upper codes active low
            act = !code[2];
        end
        ind_level = cond ? act : !act;
    endfunction

    // configuration report storage, single use
    always_comb begin
        for (int k = 1; k <= LAST_IDX; k++) begin
            cfg_d[k] = cfg_q[k];
        end
        lock_d = lock_q || i_cfg_end;
        rdata_d = rdata_q;
        if (i_cfg_wr && !lock_q) begin
            for (int k = 1; k <= LAST_IDX; k++) begin
                // (R24) reserved bits stay zero
                if (i_cfg_idx == IDX_W'(k)) begin
                    cfg_d[k] = i_cfg_wdata & wmask(k);
                end
            end
        end
        if (i_cfg_rd) begin
            rdata_d = 8'h00;
            if (i_cfg_idx == IDX_REPORT_ID) begin
                rdata_d = REPORT_ID;
            end
            for (int k = 1; k <= LAST_IDX; k++) begin
                if (i_cfg_idx == IDX_W'(k)) begin
                    rdata_d = cfg_q[k];
                end
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            // (R22) power-up defaults
            for (int k = 1; k <= LAST_IDX; k++) begin
                cfg_q[k] <= rst_val(k);
            end
            lock_q <= 1'b0;
            rdata_q <= 8'h00;
        end else begin
            for (int k = 1; k <= LAST_IDX; k++) begin
                cfg_q[k] <= cfg_d[k];
            end
            lock_q <= lock_d;
            rdata_q <= rdata_d;
        end
    end

    // GPIO function selection
    always_comb begin
        lvl_mask = {cfg_q[IDX_LVL_MSB], cfg_q[IDX_LVL_LSB]};
        drv_mask = {cfg_q[IDX_DRV_MSB], cfg_q[IDX_DRV_LSB]};
        override = drv_mask[OVERRIDE_BIT];
        force_en = '0;
        force_lvl = '0;
        gpio_lvl = i_gpio_level;
        gpio_mode[0] = dec2(cfg_q[IDX_CLK][1:0]);
        gpio_mode[2] = dec2(cfg_q[IDX_CTS][1:0]);
        gpio_mode[3] = dec2(cfg_q[IDX_RS485][1:0]);
        gpio_mode[4] = dec2(cfg_q[IDX_TX_TG][1:0]);
        gpio_mode[5] = dec2(cfg_q[IDX_RX_TG][1:0]);
        // (R5) carrier pin field
        gpio_mode[6] = dec2(cfg_q[IDX_CD][1:0]);
        // (R6) ring pin field
        gpio_mode[7] = dec2(cfg_q[IDX_RI][1:0]);
        gpio_mode[9] = dec2(cfg_q[IDX_DSR][1:0]);
        if (cfg_q[IDX_CLK][1:0] == C2_FN) begin
            gpio_mode[0] = DRV_PP;
            gpio_lvl[0] = i_clk_gen;
            // (R20) clock stopped low
            force_en[0] = 1'b1;
        end
        if (cfg_q[IDX_RS485][1:0] == C2_FN) begin
            gpio_mode[3] = DRV_PP;
            gpio_lvl[3] = i_rs485_dir ~^ cfg_q[IDX_RS485_POL][0];
            // (R21) direction enable deasserted
            force_en[3] = 1'b1;
            force_lvl[3] = !cfg_q[IDX_RS485_POL][0];
        end
        if (cfg_q[IDX_TX_TG][1:0] == C2_FN) begin
            gpio_mode[4] = DRV_PP;
            gpio_lvl[4] = i_tx_toggle_out;
        end
        if (cfg_q[IDX_RX_TG][1:0] == C2_FN) begin
            gpio_mode[5] = DRV_PP;
            gpio_lvl[5] = i_rx_toggle_out;
        end
        // (R3) handshake-out decode
        unique case (cfg_q[IDX_RTS][2:0])
            C3_IN: gpio_mode[1] = DRV_IN;
            C3_OD: gpio_mode[1] = DRV_OD;
            C3_PP: gpio_mode[1] = DRV_PP;
            C3_FN_OD: gpio_mode[1] = DRV_OD;
            C3_FN_PP: gpio_mode[1] = DRV_PP;
            default: gpio_mode[1] = DRV_IN;
        endcase
        unique case (cfg_q[IDX_DTR][2:0])
            C3_IN: gpio_mode[8] = DRV_IN;
            C3_OD: gpio_mode[8] = DRV_OD;
            C3_PP: gpio_mode[8] = DRV_PP;
            C3_FN_OD: gpio_mode[8] = DRV_OD;
            C3_FN_PP: gpio_mode[8] = DRV_PP;
            default: gpio_mode[8] = DRV_IN;
        endcase
        if (cfg_q[IDX_RTS][2:0] == C3_FN_OD || cfg_q[IDX_RTS][2:0] == C3_FN_PP) begin
            gpio_lvl[1] = i_rts_n;
        end
        if (cfg_q[IDX_DTR][2:0] == C3_FN_OD || cfg_q[IDX_DTR][2:0] == C3_FN_PP) begin
            gpio_lvl[8] = i_dtr_n;
        end
    end

    generate
        for (genvar g = 0; g < NUM_GPIO; g++) begin : g_pin
            // (R15) mask bit position of this GPIO
            localparam int MB = (g < 4) ? g : ((g < 6) ? g + 2 : g + 4);
            localparam int CI = (g == 0) ? IDX_CLK : (g == 1) ? IDX_RTS :
                (g == 2) ? IDX_CTS : (g == 3) ? IDX_RS485 : (g == 4) ? IDX_TX_TG :
                (g == 5) ? IDX_RX_TG : (g == 6) ? IDX_CD : (g == 7) ? IDX_RI :
                (g == 8) ? IDX_DTR : IDX_DSR;
            always_comb begin
                // (R1) pull-up bit
                pu_d[g] = cfg_q[CI][PULL_UP_BIT];
                // (R2) pull-down only without pull-up
                pd_d[g] = cfg_q[CI][PULL_DN_BIT] && !cfg_q[CI][PULL_UP_BIT];
            end
            pin_drive_cell u_cell (
                .i_core_clk(i_core_clk),
                .i_rst_n(i_rst_n),
                .i_mode(gpio_mode[g]),
                .i_level(gpio_lvl[g]),
                .i_suspend(i_usb_suspend),
                .i_override(override),
                .i_sus_level(lvl_mask[MB]),
                .i_sus_drive(drv_mask[MB]),
                .i_force(force_en[g]),
                .i_force_level(force_lvl[g]),
                .o_pad_out(o_pad_out[g]),
                .o_pad_oe(o_pad_oe[g])
            );
        end
    endgenerate

    // serial, indicator, function input and wakeup paths
    always_comb begin
        tx_out_d = 1'b0;
        tx_oe_d = 1'b0;
        // (R10) transmit drive type
        unique case (cfg_q[IDX_SER][1:0])
            C2_OD: tx_oe_d = !i_txd;
            C2_PP: begin
                tx_out_d = i_txd;
                tx_oe_d = 1'b1;
            end
            default: tx_oe_d = 1'b0;
        endcase
        // (R12) indicator conditions
        ind_a_d = ind_level(cfg_q[IDX_IND_A][4:2], 1'b1);
        ind_b_d = ind_level(cfg_q[IDX_IND_B][4:2], 1'b0);
        // (R14) indicator drive type
        ind_a_oe_d = (cfg_q[IDX_IND_A][1:0] == C2_PP) ||
            ((cfg_q[IDX_IND_A][1:0] == C2_OD) && !ind_a_d);
        ind_b_oe_d = (cfg_q[IDX_IND_B][1:0] == C2_PP) ||
            ((cfg_q[IDX_IND_B][1:0] == C2_OD) && !ind_b_d);
        if (cfg_q[IDX_IND_A][1:0] != C2_PP) begin
            ind_a_d = 1'b0;
        end
        if (cfg_q[IDX_IND_B][1:0] != C2_PP) begin
            ind_b_d = 1'b0;
        end
        cts_d = (cfg_q[IDX_CTS][1:0] == C2_FN) ? i_pad_in[2] : 1'b1;
        dsr_d = (cfg_q[IDX_DSR][1:0] == C2_FN) ? i_pad_in[9] : 1'b1;
        ri_d = (cfg_q[IDX_RI][1:0] == C2_FN) ? i_pad_in[7] : 1'b1;
        // (R7) ring wakeup, (R9) receive wakeup, both gated by global enable
        wake_d = i_usb_suspend && i_usb_rwake_en &&
            ((cfg_q[IDX_RI][WAKE_BIT] && pin_in_q[7] && !i_pad_in[7]) ||
            (cfg_q[IDX_SER][WAKE_BIT] && rx_in_q && !i_rx_pad_in));
        rx_pu_d = cfg_q[IDX_SER][PULL_UP_BIT];
        rx_pd_d = cfg_q[IDX_SER][PULL_DN_BIT] && !rx_pu_d;
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pu_q <= '0;
            pd_q <= '0;
            pin_in_q <= '1;
            rx_in_q <= 1'b1;
            tx_out_q <= 1'b0;
            tx_oe_q <= 1'b0;
            ind_a_q <= 1'b0;
            ind_a_oe_q <= 1'b0;
            ind_b_q <= 1'b0;
            ind_b_oe_q <= 1'b0;
            cts_q <= 1'b1;
            dsr_q <= 1'b1;
            ri_q <= 1'b1;
            {wake_q, rx_pu_q, rx_pd_q} <= 3'h0;
        end else begin
            pu_q <= pu_d;
            pd_q <= pd_d;
            pin_in_q <= i_pad_in;
            rx_in_q <= i_rx_pad_in;
            tx_out_q <= tx_out_d;
            tx_oe_q <= tx_oe_d;
            ind_a_q <= ind_a_d;
            ind_a_oe_q <= ind_a_oe_d;
            ind_b_q <= ind_b_d;
            ind_b_oe_q <= ind_b_oe_d;
            cts_q <= cts_d;
            dsr_q <= dsr_d;
            ri_q <= ri_d;
            {wake_q, rx_pu_q, rx_pd_q} <= {wake_d, rx_pu_d, rx_pd_d};
        end
    end

    assign o_cfg_rdata = rdata_q;
    assign o_cfg_locked = lock_q;
    assign o_pull_up = pu_q;
    assign o_pull_dn = pd_q;
    assign o_pin_in = pin_in_q;
    assign o_cts_in_n = cts_q;
    assign o_dsr_in_n = dsr_q;
    assign o_ri_in_n = ri_q;
    assign o_tx_out = tx_out_q;
    assign o_tx_oe = tx_oe_q;
    assign o_rx_pull_up = rx_pu_q;
    assign o_rx_pull_dn = rx_pd_q;
    assign o_bus_indicator_a = ind_a_q;
    assign o_bus_indicator_a_oe = ind_a_oe_q;
    assign o_bus_indicator_b = ind_b_q;
    assign o_bus_indicator_b_oe = ind_b_oe_q;
    assign o_wake_req = wake_q;

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_n);

    pull_excl_a: assert property ((o_pull_up & o_pull_dn) == '0) // R2
        else $error("pull-up and pull-down both on");
    carrier_pullup_a: assert property (##1 o_pull_up[6] == $past(cfg_q[IDX_CD][7])) // R1
        else $error("carrier pull-up does not follow bit 7");
    hso_reserved_a: assert property ( // R3
        cfg_q[IDX_RTS][2:0] > C3_FN_PP && !i_usb_suspend |=> !o_pad_oe[1])
        else $error("reserved handshake code drives pad");
    tx_reserved_a: assert property ( // R10
        (cfg_q[IDX_SER][1:0] == C2_IN || cfg_q[IDX_SER][1:0] == C2_FN) |=> !o_tx_oe)
        else $error("reserved transmit code drives pad");
    ind_suspend_a: assert property ( // R12
        cfg_q[IDX_IND_A][4:0] == 5'h06 && i_usb_suspend |=> o_bus_indicator_a && o_bus_indicator_a_oe)
        else $error("indicator not high in suspend");
    ind_invert_a: assert property ( // R13
        cfg_q[IDX_IND_B][4:0] == 5'h1A && i_usb_suspend |=> !o_bus_indicator_b && o_bus_indicator_b_oe)
        else $error("inverted indicator not low in suspend");
    clk_stop_a: assert property ( // R20
        i_usb_suspend && override && cfg_q[IDX_CLK][1:0] == C2_FN |=> !o_pad_out[0] && o_pad_oe[0])
        else $error("clock output not stopped low");
    rs485_idle_a: assert property ( // R21
        i_usb_suspend && override && cfg_q[IDX_RS485][1:0] == C2_FN
        |=> o_pad_out[3] == !$past(cfg_q[IDX_RS485_POL][0]))
        else $error("direction enable not deasserted");
    susp_hold_a: assert property ( // R16
        i_usb_suspend && !override ##1 i_usb_suspend && !override |-> $stable(o_pad_out))
        else $error("pad state changed during held suspend");
    wake_gate_a: assert property (o_wake_req |-> $past(i_usb_suspend) && $past(i_usb_rwake_en)) // R7
        else $error("wakeup without suspend and global enable");
    cfg_lock_a: assert property (lock_q |=> $stable(cfg_q[IDX_RTS])) // R24
        else $error("configuration changed after lock");
endmodule

/* verification/cfg_host_model.sv */
// host model that writes and reads pin report bytes
module cfg_host_model (
    input wire logic i_core_clk,
    input wire logic [7:0] i_rdata,
    output logic o_wr,
    output logic o_rd,
    output logic o_end,
    output logic o_rwake_en,
    output logic [4:0] o_idx,
    output logic [7:0] o_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {o_wr, o_rd, o_end, o_idx, o_wdata} = '0;
        o_rwake_en = 1'b1;
    end
    task automatic put(input logic [4:0] a, input logic [7:0] d, input logic e);
        @(posedge i_core_clk) #1;
        {o_wr, o_end, o_idx, o_wdata} = {~e, e, a, d};
        @(posedge i_core_clk) #1;
        {o_wr, o_end, o_wdata} = {2'b00, ~d};
    endtask
    task automatic get(input logic [4:0] a, output logic [7:0] d);
        @(posedge i_core_clk) #1;
        {o_rd, o_idx} = {1'b1, a};
        @(posedge i_core_clk) #1;
        o_rd = 1'b0;
        d = i_rdata;
    endtask
endmodule

/* verification/gpio_pin_function_config_tb_top.sv */
// bench for the pin function configuration block
module gpio_pin_function_config_tb_top import pin_cfg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk, i_rst_n, i_cfg_wr, i_cfg_rd, i_cfg_end, i_usb_suspend, i_usb_bus_reset;
    logic i_usb_configured, i_usb_rwake_en, i_rx_pad_in, i_txd, i_rts_n, i_dtr_n, i_clk_gen;
    logic i_rs485_dir, i_tx_toggle_out, i_rx_toggle_out, o_cfg_locked, o_cts_in_n, o_dsr_in_n;
    logic o_ri_in_n, o_tx_out, o_tx_oe, o_rx_pull_up, o_rx_pull_dn, o_bus_indicator_a;
    logic o_bus_indicator_a_oe, o_bus_indicator_b, o_bus_indicator_b_oe, o_wake_req;
    logic [IDX_W-1:0] i_cfg_idx;
    logic [7:0] i_cfg_wdata, o_cfg_rdata, v;
    logic [NUM_GPIO-1:0] i_gpio_level, i_pad_in, o_pad_out, o_pad_oe, o_pull_up, o_pull_dn;
    logic [NUM_GPIO-1:0] o_pin_in;
    int err_count = 0, compares = 0, cyc = 0;
    localparam logic [15:0] DFL [8] = '{16'h0066, 16'h0203, 16'h0700, 16'h0800, 16'h0B02,
        16'h0C0A, 16'h0D1A, 16'h1400};
    localparam logic [15:0] RSV [5] = '{16'h07C3, 16'h08E3, 16'h0C1F, 16'h02C7, 16'h0BE3};
    localparam logic [2:0] CND [3] = '{3'b001, 3'b100, 3'b011};
    cfg_host_model u_host (.i_core_clk(i_core_clk), .i_rdata(o_cfg_rdata), .o_wr(i_cfg_wr),
        .o_rd(i_cfg_rd), .o_end(i_cfg_end), .o_rwake_en(i_usb_rwake_en), .o_idx(i_cfg_idx),
        .o_wdata(i_cfg_wdata));
    gpio_pin_function_config u_dut (.*);
    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic close_out();
        if (err_count == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic w2();
        repeat (2) @(posedge i_core_clk);
        #1;
    endtask
    // expected pad pair {out, oe}: mode 0 input, 1 open-drain, 2 push-pull
    function automatic logic [1:0] drv(input int m, input logic s);
        return (m == 0) ? 2'b00 : (m == 1) ? {1'b0, !s} : {s, 1'b1};
    endfunction
    function automatic logic ind(input logic [2:0] c, input logic s, r, f);
        logic a;
        case (c[1:0])
            2'b00: a = s | r;
            2'b01: a = s;
            2'b10: a = s | !f;
            default: a = r;
        endcase
        return (c[2] && c[1:0] != 2'b00) ? !a : a;
    endfunction
    always @(posedge i_core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        {i_rst_n, i_usb_suspend, i_usb_bus_reset, i_usb_configured, i_rx_pad_in} = 5'b00011;
        {i_txd, i_rts_n, i_dtr_n, i_clk_gen, i_rs485_dir} = 5'b11100;
        {i_tx_toggle_out, i_rx_toggle_out, i_gpio_level, i_pad_in} = {2'b00, 10'h100, 10'h3FF};
        repeat (6) @(posedge i_core_clk);
        #1;
        i_rst_n = 1'b1;
        w2();
        chk("pad8", 3'b111, {o_pad_out[8], o_pad_oe[8], o_tx_oe});
        foreach (DFL[i]) begin
            u_host.get(DFL[i][12:8], v);
            chk("dflt", DFL[i][7:0], v);
        end
        foreach (RSV[i]) begin
            u_host.put(RSV[i][12:8], 8'hFF, 1'b0);
            u_host.get(RSV[i][12:8], v);
            chk("rsvd", RSV[i][7:0], v);
        end
        chk("pull", 4'b1000, {o_pull_up[6], o_pull_dn[6], o_pad_oe[6], o_pad_oe[1]});
        for (int c = 0; c < 3; c++) begin
            i_gpio_level[6] = c[1];
            u_host.put(IDX_CD, 8'h40 | 8'(c), 1'b0);
            w2();
            chk("cd", {1'b1, drv(c, c[1])}, {o_pull_dn[6], o_pad_out[6], o_pad_oe[6]});
        end
        for (int c = 0; c < 5; c++) begin
            u_host.put(IDX_RTS, 8'(c), 1'b0);
            for (int k = 0; k < 2; k++) begin
                {i_gpio_level[1], i_rts_n} = {k[0], !k[0]};
                w2();
                v[0] = (c < 3) ? i_gpio_level[1] : i_rts_n;
                chk("rts", drv((c == 0) ? 0 : (c[0] ? 1 : 2), v[0]), {o_pad_out[1], o_pad_oe[1]});
            end
        end
        for (int k = 0; k < 2; k++) begin
            i_txd = k[0];
            u_host.put(IDX_SER, k[0] ? 8'h82 : 8'h41, 1'b0);
            w2();
            chk("ser", {k[0], !k[0], drv(k + 1, k[0])},
                {o_rx_pull_up, o_rx_pull_dn, o_tx_out, o_tx_oe});
        end
        for (int c = 0; c < 8; c++) begin
            u_host.put(IDX_IND_A, {3'b000, 3'(c), 2'b10}, 1'b0);
            foreach (CND[k]) begin
                {i_usb_suspend, i_usb_bus_reset, i_usb_configured} = CND[k];
                w2();
                chk("ind", {ind(3'(c), CND[k][2], CND[k][1], CND[k][0]), 1'b1,
                    ind(3'h6, CND[k][2], CND[k][1], CND[k][0]), 1'b1}, {o_bus_indicator_a,
                    o_bus_indicator_a_oe, o_bus_indicator_b, o_bus_indicator_b_oe});
            end
        end
        u_host.put(IDX_RI, 8'h23, 1'b0);
        {i_usb_suspend, i_usb_bus_reset, i_pad_in[7], i_pad_in[2]} = 4'h0;
        w2();
        chk("ring", 4'h2, {o_ri_in_n, o_cts_in_n, o_dsr_in_n, o_pin_in[7]});
        {i_usb_suspend, i_pad_in[7]} = 2'b11;
        w2();
        {i_gpio_level[8], i_pad_in[7], i_rx_pad_in} = 3'b000;
        v = '0;
        repeat (4) begin
            @(posedge i_core_clk);
            #1;
            v[0] = v[0] | o_wake_req;
        end
        chk("wake_hold", 2'b11, {v[0], o_pad_out[8]});
        u_host.put(IDX_LVL_LSB, 8'h0B, 1'b0);
        u_host.put(IDX_CLK, 8'h03, 1'b0);
        u_host.put(IDX_DRV_MSB, 8'h90, 1'b0);
        w2();
        chk("sleep", 8'h45, {o_pad_out[8], o_pad_oe[8], o_pad_out[1], o_pad_oe[1],
            o_pad_out[3], o_pad_oe[3], o_pad_out[0], o_pad_oe[0]});
        u_host.put(5'h14, 8'h00, 1'b1);
        u_host.put(IDX_CD, 8'h00, 1'b0);
        u_host.get(IDX_CD, v);
        chk("lock", 9'h142, {o_cfg_locked, v});
        close_out();
    end
endmodule
